// *** logic/tmr_pkg.sv ***
// Shared constants and carrier types for the dual 8-bit timer/counter
package tmr_pkg;
  // Control register bit positions
  localparam int CTL_FLOP_BIT = 7;   // Output flip-flop load value
  localparam int CTL_CLK_HI   = 6;   // Source clock select, top bit
  localparam int CTL_CLK_LO   = 4;   // Source clock select, low bit
  localparam int CTL_RUN_BIT  = 3;   // Counter start
  localparam int CTL_MODE_HI  = 2;   // Operating mode, top bit
  localparam int CTL_MODE_LO  = 0;   // Operating mode, low bit
  localparam logic [7:0] CTL_RESET = 8'h00;  // Control reset value
  localparam logic [7:0] CMP_RESET = 8'hff;  // Compare reset value
  localparam logic [7:0] PWM_RESET = 8'hff;  // Duty reset value
  // Operating modes
  localparam logic [2:0] MODE_TIMER = 3'h0;  // Timer or event counter
  localparam logic [2:0] MODE_DIV   = 3'h1;  // Divider output
  localparam logic [2:0] MODE_PWM   = 3'h2;  // 8-bit PWM
  // Clock selections
  localparam logic [2:0] CLK_DIV11 = 3'h0;
  localparam logic [2:0] CLK_DIV7  = 3'h1;
  localparam logic [2:0] CLK_DIV5  = 3'h2;
  localparam logic [2:0] CLK_DIV3  = 3'h3;
  localparam logic [2:0] CLK_DIV1  = 3'h5;
  localparam logic [2:0] CLK_FULL  = 3'h6;
  localparam logic [2:0] CLK_PIN   = 3'h7;
  // Prescaler width gives the deepest tap, high_freq_clock / 2^11
  localparam int PRESCALE_BITS = 11;
  // Register write strobes of one channel
  typedef struct packed {
    logic       ctl_we;   // Control write
    logic       cmp_we;   // Compare write
    logic       pwm_we;   // Duty write
    logic [7:0] wdata;    // Write data
  } wr_t;
  // Observed state of one channel
  typedef struct packed {
    logic [7:0] count;    // Counter value
    logic [7:0] pwm_rd;   // Duty read-back
    logic       flop;     // Output flip-flop
  } stat_t;
endpackage

// *** logic/tmr_channel.sv ***
// One 8-bit timer/counter channel with compare, duty shadow and output flop
`timescale 1ns/1ns
`default_nettype none
module tmr_channel
(
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  input  wire tmr_pkg::wr_t           wr,
  input  wire logic [tmr_pkg::PRESCALE_BITS-1:0] taps,
  input  wire logic                   event_fall,
  output tmr_pkg::stat_t              stat,
  output logic                        irq,
  output logic                        div_out,
  output logic                        pwm_out
);
  logic [7:0] ctl, next_ctl;          // Control register
  logic [7:0] cmp, next_cmp;          // Compare register
  logic [7:0] pwm_act, next_pwm_act;  // Active duty register
  logic [7:0] pwm_shd, next_pwm_shd;  // Duty shadow stage
  logic [7:0] count, next_count;      // Up-counter
  logic       flop, next_flop;        // Output flip-flop
  logic       irq_q, next_irq;        // Interrupt pulse
  logic       div_q, next_div;        // Divider pin
  logic       pwm_q, next_pwm;        // PWM pin
  logic [7:0] pwm_rd, next_pwm_rd;    // Duty read-back register
  logic       stop_wr;                // Control write that clears run
  logic [tmr_pkg::PRESCALE_BITS-1:0] taps_d;  // Delayed taps for edge pick
  logic       tick;                   // Selected source clock edge
  logic       run;                    // Counter started
  logic [2:0] mode;                   // Operating mode
  logic [2:0] csel;                   // Clock selection

  assign run  = ctl[tmr_pkg::CTL_RUN_BIT];
  assign mode = ctl[tmr_pkg::CTL_MODE_HI:tmr_pkg::CTL_MODE_LO];
  assign csel = ctl[tmr_pkg::CTL_CLK_HI:tmr_pkg::CTL_CLK_LO];
  // A stop write halts counting in its own cycle so the pins cannot move
  assign stop_wr = wr.ctl_we & ~wr.wdata[tmr_pkg::CTL_RUN_BIT];

  // Source clock selection as a rising edge of a prescaler tap, the full core clock or an event pin fall
  always_comb
  begin
    unique case (csel)
      tmr_pkg::CLK_DIV11: tick = taps[10] & ~taps_d[10];
      tmr_pkg::CLK_DIV7:  tick = taps[6] & ~taps_d[6];
      tmr_pkg::CLK_DIV5:  tick = taps[4] & ~taps_d[4];
      tmr_pkg::CLK_DIV3:  tick = taps[2] & ~taps_d[2];
      tmr_pkg::CLK_DIV1:  tick = (mode == tmr_pkg::MODE_PWM) & taps[0] & ~taps_d[0];
      tmr_pkg::CLK_FULL:  tick = (mode == tmr_pkg::MODE_PWM);
      tmr_pkg::CLK_PIN:   tick = (mode == tmr_pkg::MODE_TIMER) & event_fall;
      default:            tick = 1'b0;  // Reserved selection
    endcase
  end

  // Next-state logic for registers, counter and pins
  always_comb
  begin
    next_ctl     = ctl;
    next_cmp     = cmp;
    next_pwm_act = pwm_act;
    next_pwm_shd = pwm_shd;
    next_count   = count;
    next_flop    = flop;
    next_irq     = 1'b0;
    if (wr.cmp_we)
      next_cmp = wr.wdata;
    if (wr.pwm_we)
      next_pwm_shd = wr.wdata;
    if (!run || stop_wr)
    begin
      next_count = 8'h00;
      if (wr.pwm_we)
        next_pwm_act = wr.wdata;
    end
    else if (tick)
    begin
      if (mode == tmr_pkg::MODE_PWM)
      begin
        next_count = count + 8'h01;
        if (count == pwm_act)
          next_flop = ~flop;
        if (count == 8'hff)
        begin
          next_flop    = ~flop;
          next_irq     = 1'b1;
          next_pwm_act = wr.pwm_we ? wr.wdata : pwm_shd;
        end
      end
      else if (count + 8'h01 == cmp)
      begin
        next_count = 8'h00;
        next_irq   = 1'b1;
        if (mode == tmr_pkg::MODE_DIV)
          next_flop = ~flop;
      end
      else
        next_count = count + 8'h01;
    end
    if (wr.ctl_we)
    begin
      next_ctl = wr.wdata;
      // Flop bit is ignored in the write that stops a running counter
      if (!(run && !wr.wdata[tmr_pkg::CTL_RUN_BIT]))
        next_flop = wr.wdata[tmr_pkg::CTL_FLOP_BIT];
    end
    // Pins show the inverse flop level and hold it while stopped
    next_div = ~next_flop;
    next_pwm = ~next_flop;
    // In PWM mode a new duty reads back only after it becomes active
    if (next_ctl[tmr_pkg::CTL_MODE_HI:tmr_pkg::CTL_MODE_LO] == tmr_pkg::MODE_PWM)
      next_pwm_rd = next_pwm_act;
    else
      next_pwm_rd = next_pwm_shd;
  end

  // Register stage
  always_ff @(posedge core_clk)
  begin
    taps_d <= taps;
    if (srst)
    begin
      ctl     <= tmr_pkg::CTL_RESET;
      cmp     <= tmr_pkg::CMP_RESET;
      pwm_act <= tmr_pkg::PWM_RESET;
      pwm_shd <= tmr_pkg::PWM_RESET;
      count   <= 8'h00;
      flop    <= 1'b0;
      irq_q   <= 1'b0;
      div_q   <= 1'b1;
      pwm_q   <= 1'b1;
      pwm_rd  <= tmr_pkg::PWM_RESET;
    end
    else
    begin
      ctl     <= next_ctl;
      cmp     <= next_cmp;
      pwm_act <= next_pwm_act;
      pwm_shd <= next_pwm_shd;
      count   <= next_count;
      flop    <= next_flop;
      irq_q   <= next_irq;
      div_q   <= next_div;
      pwm_q   <= next_pwm;
      pwm_rd  <= next_pwm_rd;
    end
  end

  // Status fields all come straight from registers
  assign stat        = '{count: count, pwm_rd: pwm_rd, flop: flop};
  assign irq         = irq_q;
  assign div_out     = div_q;
  assign pwm_out     = pwm_q;
endmodule
`default_nettype wire

// *** logic/tmr_dual.sv ***
// Top: prescaler, event pin synchronisers and two timer/counter channels
`timescale 1ns/1ns
`default_nettype none
//Contract
// - Timer mode counts, matches compare, interrupts, clears
// - Compare writes take effect immediately, no shadow
// - Four prescaled clocks: divide by 2^11,7,5,3
// - Event mode counts input falling edges
// - Divider mode toggles flop on match, interrupts
// - Divider pin shows inverted flop
// - Flop loadable by control; reset clears it
// - Stopped pin holds level; stop write ignores flop
// - Clear run bit stops; clear flop drives high
// - PWM toggles at duty match and overflow
// - PWM pin shows inverted flop
// - Duty write shadowed, loads on interrupt or stopped
// - Duty read returns active duty during PWM, shadow otherwise
// - PWM adds half and full rate clocks
// - Run bit zero stops and clears count
module tmr_dual
(
  input  wire logic                    CORE_CLK,
  input  wire logic                    SRST,
  input  wire tmr_pkg::wr_t            WR_A,
  input  wire tmr_pkg::wr_t            WR_B,
  input  wire logic                    EVENT_IN_PIN_A,
  input  wire logic                    EVENT_IN_PIN_B,
  output tmr_pkg::stat_t               STAT_A,
  output tmr_pkg::stat_t               STAT_B,
  output logic                         COUNTER_IRQ_A,
  output logic                         COUNTER_IRQ_B,
  output logic                         DIVIDER_OUT_PIN_A,
  output logic                         DIVIDER_OUT_PIN_B,
  output logic                         PWM_OUT_PIN_A,
  output logic                         PWM_OUT_PIN_B
);
  logic [tmr_pkg::PRESCALE_BITS-1:0] taps, next_taps;  // Shared prescaler
  logic [1:0] sync1, sync2, sync3;  // Event pin synchronisers and history
  logic [1:0] fall;                 // Falling edges of synchronised pins

  // Prescaler advances every core clock
  always_comb
  begin
    next_taps = taps + 11'h001;
  end

  // Prescaler and pin synchroniser registers
  always_ff @(posedge CORE_CLK)
  begin
    sync1 <= {EVENT_IN_PIN_B, EVENT_IN_PIN_A};
    sync2 <= sync1;
    sync3 <= sync2;
    if (SRST)
      taps <= '0;
    else
      taps <= next_taps;
  end

  // Falling edge seen on the synchronised level only
  assign fall = sync3 & ~sync2;

  // Channel A
  tmr_channel u_a
  (
    .core_clk   (CORE_CLK),
    .srst       (SRST),
    .wr         (WR_A),
    .taps       (taps),
    .event_fall (fall[0]),
    .stat       (STAT_A),
    .irq        (COUNTER_IRQ_A),
    .div_out    (DIVIDER_OUT_PIN_A),
    .pwm_out    (PWM_OUT_PIN_A)
  );

  // Channel B
  tmr_channel u_b
  (
    .core_clk   (CORE_CLK),
    .srst       (SRST),
    .wr         (WR_B),
    .taps       (taps),
    .event_fall (fall[1]),
    .stat       (STAT_B),
    .irq        (COUNTER_IRQ_B),
    .div_out    (DIVIDER_OUT_PIN_B),
    .pwm_out    (PWM_OUT_PIN_B)
  );
endmodule
`default_nettype wire

// *** tb/tmr_dual_monitor.sv ***
// Port-level checker for the dual timer
`timescale 1ns/1ns
`default_nettype none
module tmr_dual_monitor
(
  input wire logic           CORE_CLK,
  input wire logic           SRST,
  input wire tmr_pkg::wr_t   WR_A,
  input wire tmr_pkg::stat_t STAT_A,
  input wire tmr_pkg::stat_t STAT_B,
  input wire logic           COUNTER_IRQ_A,
  input wire logic           DIVIDER_OUT_PIN_A,
  input wire logic           DIVIDER_OUT_PIN_B,
  input wire logic           PWM_OUT_PIN_A,
  input wire logic           PWM_OUT_PIN_B
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  logic run; // Channel A run bit as last written
  // Track the run bit from control writes
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      run <= 1'b0;
    else if (WR_A.ctl_we)
      run <= WR_A.wdata[3];
  end
  AST_DIV_INV: assert property (DIVIDER_OUT_PIN_A != STAT_A.flop &&
    DIVIDER_OUT_PIN_B != STAT_B.flop) else $error("divider pin not inverted flop");
  AST_PWM_INV: assert property (PWM_OUT_PIN_A != STAT_A.flop &&
    PWM_OUT_PIN_B != STAT_B.flop) else $error("pwm pin not inverted flop");
  AST_IRQ_PULSE: assert property (COUNTER_IRQ_A |=> !COUNTER_IRQ_A)
    else $error("irq longer than one cycle");
  AST_RESET: assert property ($fell(SRST) |-> STAT_A.flop == 1'b0 &&
    STAT_A.count == 8'h00 && !COUNTER_IRQ_A) else $error("bad state after reset");
  AST_STOP_CLR: assert property (WR_A.ctl_we && !WR_A.wdata[3]
    |=> STAT_A.count == 8'h00) else $error("stop did not clear count");
  AST_IDLE: assert property (!run && !WR_A.ctl_we |=> $stable(STAT_A.count))
    else $error("count moved while stopped");
  AST_FLOP_LOAD: assert property (WR_A.ctl_we && !run
    |=> STAT_A.flop == $past(WR_A.wdata[7])) else $error("flop not loaded");
  AST_STOP_HOLD: assert property (WR_A.ctl_we && run && !WR_A.wdata[3]
    |=> $stable(STAT_A.flop)) else $error("flop changed by stop write");
endmodule
bind tmr_dual tmr_dual_monitor tmr_dual_monitor_i (.CORE_CLK, .SRST, .WR_A, .STAT_A,
  .STAT_B, .COUNTER_IRQ_A, .DIVIDER_OUT_PIN_A, .DIVIDER_OUT_PIN_B, .PWM_OUT_PIN_A,
  .PWM_OUT_PIN_B);
`default_nettype wire

// *** tb/evt_src.sv ***
// Event source driving falling edges onto an event pin
`timescale 1ns/1ns
`default_nettype none
module evt_src
(
  input  wire logic clk,
  input  wire logic en,
  output var logic  pin = 1'b1
);
  logic [3:0] ph = 4'h0; // Phase within one event
  // Each level lasts eight clocks, two machine cycles; idle level is high
  always @(posedge clk)
  begin
    ph <= en ? ph + 4'h1 : 4'h0;
    pin <= #1 !(en && ph[3]);
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the dual timer
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 0, srst = 1, en = 0, f;
  tmr_pkg::wr_t wa = '0, wb = '0;
  tmr_pkg::stat_t sa, sb;
  logic ia, ib, da, db, pa, pb, ea;
  int bad_count = 0, num_checks = 0, cyc = 0, t, n, d;
  logic [31:0] rs = 32'he5b50434; // Random state
  evt_src evt_src_i (.clk(clk), .en(en), .pin(ea));
  tmr_dual tmr_dual_i (.CORE_CLK(clk), .SRST(srst), .WR_A(wa), .WR_B(wb),
    .EVENT_IN_PIN_A(ea), .EVENT_IN_PIN_B(1'b1), .STAT_A(sa), .STAT_B(sb),
    .COUNTER_IRQ_A(ia), .COUNTER_IRQ_B(ib), .DIVIDER_OUT_PIN_A(da),
    .DIVIDER_OUT_PIN_B(db), .PWM_OUT_PIN_A(pa), .PWM_OUT_PIN_B(pb));
  always #50 clk = ~clk;
  // Cycle ceiling against hangs
  always @(posedge clk)
    if (++cyc > 30000) begin bad_count++; close_out(); end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(string nm, int e, logic [15:0] s);
    num_checks++;
    if (s !== 16'(e)) begin bad_count++; $display("ERROR %s exp %0h got %0h", nm, e, s); end
  endtask
  // One write strobe: k 0 control, 1 compare, 2 duty
  task automatic wr(bit b, int k, logic [7:0] v);
    tmr_pkg::wr_t w;
    w = '0; w.wdata = v; w.ctl_we = (k == 0); w.cmp_we = (k == 1); w.pwm_we = (k == 2);
    @(posedge clk); #1; if (b) wb = w; else wa = w;
    @(posedge clk); #1; wa = '0; wb = '0;
  endtask
  // Wait for an irq pulse, cycles in c
  task automatic wirq(bit b, output int c);
    c = 0;
    do begin @(posedge clk); #1; c++; end while ((b ? ib : ia) !== 1'b1 && c < 3000);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    #1 srst = 0;
    chk("rst", 16'h00ff, {sa.count, sa.pwm_rd});
    chk("pins", 3, 16'({da, pa}));
    rs = lfsr(rs);
    n = 2 + rs[1:0];
    // Timer on the divide-by-128 clock, compare in range, flop bit zero
    wr(0, 1, 8'(n));
    wr(0, 0, 8'h18);
    wirq(0, t);
    wirq(0, t);
    chk("tmr_per", n * 128, 16'(t));
    // Stop before the compare is rewritten, then divider on divide-by-32
    wr(0, 0, 8'h20);
    wr(0, 1, 8'(n + 1));
    wr(0, 0, 8'h29);
    wirq(0, t);
    f = sa.flop;
    wirq(0, t);
    chk("div_per", (n + 1) * 32, 16'(t));
    chk("div_tog", !f, 16'(sa.flop));
    f = sa.flop;
    wr(0, 0, 8'ha1);
    chk("stop_hold", f, 16'(sa.flop));
    chk("stop_clr", 0, 16'(sa.count));
    wr(0, 0, 8'h80);
    chk("ld1", 0, 16'(da));
    wr(0, 0, 8'h00);
    chk("ld0", 1, 16'(da));
    rs = lfsr(rs);
    d = 2 + (rs % 253);
    wr(1, 2, 8'(d));
    wr(1, 0, 8'h6a);
    wirq(1, t);
    f = sb.flop;
    chk("pwm_cnt", 0, 16'(sb.count));
    n = 0;
    repeat (256)
    begin
      @(posedge clk);
      #1;
      if (sb.flop !== f)
        n++;
    end
    chk("pwm_duty", 255 - d, 16'(n));
    chk("pwm_per", 1, 16'(ib));
    chk("pwm_pin", !sb.flop, 16'(pb));
    chk("div_b", !sb.flop, 16'(db));
    // New duty written just after the interrupt
    wr(1, 2, 8'(256 - d));
    chk("shd_rd", d, 16'(sb.pwm_rd));
    wirq(1, t);
    chk("shd_ld", 256 - d, 16'(sb.pwm_rd));
    // Stop ahead of any low-power entry; flop bit in the stop write is ignored
    f = sb.flop;
    wr(1, 0, 8'he2);
    chk("pwm_hold", !f, 16'(pb));
    chk("pwm_clr", 0, 16'(sb.count));
    wr(0, 1, 8'h03);
    wr(0, 0, 8'h78);
    en = 1;
    wirq(0, t);
    wirq(0, t);
    chk("evt_per", 48, 16'(t));
    en = 0;
    close_out();
  end
endmodule
`default_nettype wire
